// File: hdl/bfu_defs.svh
`ifndef BFU_DEFS_SVH
`define BFU_DEFS_SVH
// How it works
// - queue holds at most six instruction bytes
// - fetch a word when two slots free
// - fifo order; first byte shown at once
// - twenty-bit physical byte address
// - segments 64K, start on 16-byte boundary
// - low byte at lower address
// - odd word operand takes two cycles
// - code fetches always whole words
// - two banks addressed by bits 19..1
// - even bytes low lane, odd high
// - high byte enable with address bit zero
// - start fetching at FFFF0 after reset
// - low 1K holds 256 four-byte vectors
// - strap low: status drives bus controller
// - address and data share one bus
// - four phases, address in first
// - data in phases two to four
// - wait states between three and four
// - idle clocks allowed between cycles
// - latch strobe pulses in first phase
// - active-low three-bit cycle type codes
// - status 3..7 valid phases two to four
// - segment status codes
// - int enable mirror, zero bit, spare
`define BFU_QUEUE_DEPTH   6
`define BFU_RESET_SEG     16'hFFFF
`define BFU_RESET_OFF     16'h0000
`define BFU_VEC_LIMIT     20'h003FF
`define BFU_ST_INTA       3'h0
`define BFU_ST_IORD       3'h1
`define BFU_ST_IOWR       3'h2
`define BFU_ST_HALT       3'h3
`define BFU_ST_FETCH      3'h4
`define BFU_ST_MEMRD      3'h5
`define BFU_ST_MEMWR      3'h6
`define BFU_ST_PASSIVE    3'h7
`define BFU_SEG_ALT       2'h0
`define BFU_SEG_STACK     2'h1
`define BFU_SEG_CODE      2'h2
`define BFU_SEG_DATA      2'h3
`endif

// File: hdl/bfu_pkg.sv
package bfu_pkg;
	typedef enum logic [2:0] {
		BFU_IDLE       = 3'b000,
		BFU_ADDRESS    = 3'b001,
		BFU_TURNAROUND = 3'b010,
		BFU_DATA_FIRST = 3'b011,
		BFU_WAIT       = 3'b100,
		BFU_DATA_LAST  = 3'b101
	} bfu_phase_t;
endpackage : bfu_pkg

// File: hdl/bfu_fifo.sv
`timescale 1ns/100ps
module bfu_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic [WIDTH-1:0] i_data,
	input  wire logic             i_valid,
	output logic                  o_ready,
	output logic [WIDTH-1:0]      o_data,
	output logic                  o_valid,
	input  wire logic             i_ready,
	output logic [$clog2(DEPTH+1)-1:0] o_count
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic             push;
	logic             pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH-1)) ? '0 : p + 1'b1;
	endfunction : bump

	assign o_ready = o_count != ($clog2(DEPTH+1))'(DEPTH);
	assign o_valid = o_count != '0;
	assign o_data  = mem[rd_ptr];
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;

	always_ff @(posedge i_clk) begin
		if (push)
			mem[wr_ptr] <= i_data;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wr_ptr  <= '0;
			rd_ptr  <= '0;
			o_count <= '0;
		end else begin
			if (push)
				wr_ptr <= bump(wr_ptr);
			if (pop)
				rd_ptr <= bump(rd_ptr);
			if (push && !pop)
				o_count <= o_count + 1'b1;
			else if (pop && !push)
				o_count <= o_count - 1'b1;
		end
	end
endmodule : bfu_fifo

// File: hdl/bfu_core.sv
`timescale 1ns/100ps
`include "bfu_defs.svh"
module bfu_core
	import bfu_pkg::*;
#(
	parameter int QUEUE_DEPTH = `BFU_QUEUE_DEPTH,
	parameter int FIFO_DEPTH  = 8
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_mode_strap,
	input  wire logic        i_ready,
	input  wire logic        i_int_enable,
	input  wire logic        i_flush,
	input  wire logic [15:0] i_flush_seg,
	input  wire logic [15:0] i_flush_off,
	input  wire logic        i_op_req,
	input  wire logic [2:0]  i_op_type,
	input  wire logic [1:0]  i_op_seg_sel,
	input  wire logic [15:0] i_op_seg,
	input  wire logic [15:0] i_op_off,
	input  wire logic        i_op_word,
	input  wire logic [15:0] i_op_wdata,
	output logic             o_op_busy,
	output logic             o_op_done,
	output logic [15:0]      o_op_rdata,
	output logic [7:0]       o_instr_byte,
	output logic             o_instr_valid,
	input  wire logic        i_instr_take,
	input  wire logic [15:0] i_ad_in,
	output logic [15:0]      o_ad_out,
	output logic             o_ad_oe_n,
	output logic [3:0]       o_addr_status,
	output logic             o_high_byte_enable_n,
	output logic [2:0]       o_cycle_type_status,
	output logic             o_addr_latch,
	output logic             o_read_n,
	output logic             o_write_n,
	output logic             o_mem_io
);
	bfu_phase_t  phase;
	logic [19:0] cyc_addr;
	logic        cyc_fetch;
	logic        cyc_second;
	logic        cyc_hi_only;
	logic        cyc_lo_only;
	logic [2:0]  cyc_type;
	logic [1:0]  cyc_seg;
	logic [15:0] cyc_wdata;
	logic [15:0] code_seg;
	logic [15:0] fetch_ip;
	logic        op_pend;
	logic        op_second;
	logic [7:0]  op_lo;
	logic        op_odd;
	logic [3:0]  inflight;
	logic        fifo_ready;
	logic        fifo_push;
	logic [7:0]  fifo_data;
	logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_count;
	logic        end_cycle;
	logic        start_fetch;
	logic        start_op;
	logic [3:0]  pending;
	logic        bytes_two;
	logic        op_done_q;
	logic        skip_lo;
	logic        lo_now;
	logic        cyc_stale;
	logic        fetch_done;
	logic        vec_access;
	logic [19:0] fetch_phys;
	logic [19:0] next_cyc_addr;
	logic [2:0]  next_cyc_type;
	logic [1:0]  next_cyc_seg;
	logic        next_cyc_hi_only;
	logic        next_cyc_lo_only;
	logic [15:0] next_cyc_wdata;
	bfu_phase_t  next_phase_view;

	// segment base shifted by four bits plus offset
	function automatic logic [19:0] phys(input logic [15:0] s,
		input logic [15:0] o);
		phys = {s, 4'h0} + {4'h0, o};
	endfunction : phys

	// queue occupancy counts buffered bytes plus those of the fetch in flight
	assign pending     = 4'(fifo_count) + inflight;
	assign end_cycle   = phase == BFU_DATA_LAST;
	assign start_op    = phase == BFU_IDLE && op_pend && !i_flush;
	assign start_fetch = phase == BFU_IDLE && !op_pend && !i_flush
		&& (4'(QUEUE_DEPTH) - pending >= 4'h2);
	assign o_op_busy   = op_pend;

	// op capture, odd word splits in two cycles
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			op_pend   <= 1'b0;
			op_second <= 1'b0;
			op_done_q <= 1'b0;
		end else begin
			op_done_q <= 1'b0;
			if (i_op_req && !op_pend) begin
				op_pend   <= 1'b1;
				op_second <= 1'b0;
			end else if (end_cycle && !cyc_fetch) begin
				if (op_odd && !op_second)
					op_second <= 1'b1;
				else begin
					op_pend   <= 1'b0;
					op_done_q <= 1'b1;
				end
			end
		end
	end
	assign o_op_done = op_done_q;

	logic [2:0]  op_type_q;
	logic [1:0]  op_seg_q;
	logic [19:0] op_addr;
	logic        op_word_q;
	logic [15:0] op_wdata_q;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			op_type_q  <= `BFU_ST_PASSIVE;
			op_seg_q   <= `BFU_SEG_DATA;
			op_addr    <= '0;
			op_word_q  <= 1'b0;
			op_wdata_q <= '0;
			op_odd     <= 1'b0;
		end else if (i_op_req && !op_pend) begin
			op_type_q  <= i_op_type;
			op_seg_q   <= i_op_seg_sel;
			op_addr    <= phys(i_op_seg, i_op_off);
			op_word_q  <= i_op_word;
			op_wdata_q <= i_op_wdata;
			op_odd     <= i_op_word && i_op_off[0];
		end
	end

	// phase sequencer, extra idles between cycles
	always_ff @(posedge i_clk) begin
		if (i_rst)
			phase <= BFU_IDLE;
		else begin
			case (phase)
			BFU_IDLE:
				if (start_op || start_fetch)
					phase <= BFU_ADDRESS;
			BFU_ADDRESS:    phase <= BFU_TURNAROUND;
			BFU_TURNAROUND: phase <= BFU_DATA_FIRST;
			BFU_DATA_FIRST:
				phase <= i_ready ? BFU_DATA_LAST : BFU_WAIT;
			BFU_WAIT:
				phase <= i_ready ? BFU_DATA_LAST : BFU_WAIT;
			BFU_DATA_LAST:  phase <= BFU_IDLE;
			default:        phase <= BFU_IDLE;
			endcase
		end
	end

	// next cycle: operand piece or word fetch, also feeds the T1 pins
	assign fetch_phys = phys(code_seg, fetch_ip);
	always_comb begin
		next_cyc_addr    = {fetch_phys[19:1], 1'b0};
		next_cyc_type    = `BFU_ST_FETCH;
		next_cyc_seg     = `BFU_SEG_CODE;
		next_cyc_hi_only = 1'b0;
		next_cyc_lo_only = 1'b0;
		next_cyc_wdata   = cyc_wdata;
		if (start_op) begin
			next_cyc_type = op_type_q;
			next_cyc_seg  = op_seg_q;
			if (op_second) begin
				next_cyc_addr    = op_addr + 20'h1;
				next_cyc_lo_only = 1'b1;
				next_cyc_wdata   = {8'h00, op_wdata_q[15:8]};
			end else if (op_odd || (!op_word_q && op_addr[0])) begin
				next_cyc_addr    = op_addr;
				next_cyc_hi_only = 1'b1;
				next_cyc_wdata   = {op_wdata_q[7:0], 8'h00};
			end else begin
				next_cyc_addr    = op_addr;
				next_cyc_lo_only = !op_word_q;
				next_cyc_wdata   = op_wdata_q;
			end
		end
	end

	// cycle setup, held from T1 to the end of the cycle
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cyc_addr    <= '0;
			cyc_fetch   <= 1'b0;
			cyc_type    <= `BFU_ST_PASSIVE;
			cyc_seg     <= `BFU_SEG_CODE;
			cyc_hi_only <= 1'b0;
			cyc_lo_only <= 1'b0;
			cyc_wdata   <= '0;
			cyc_second  <= 1'b0;
		end else if (start_op || start_fetch) begin
			cyc_addr    <= next_cyc_addr;
			cyc_fetch   <= !start_op;
			cyc_type    <= next_cyc_type;
			cyc_seg     <= next_cyc_seg;
			cyc_hi_only <= next_cyc_hi_only;
			cyc_lo_only <= next_cyc_lo_only;
			cyc_wdata   <= next_cyc_wdata;
			cyc_second  <= start_op && op_second;
		end
	end

	// fetch pointer, reset vector, flush
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			code_seg <= `BFU_RESET_SEG;
			fetch_ip <= `BFU_RESET_OFF;
			skip_lo  <= 1'b0;
		end else if (i_flush) begin
			code_seg <= i_flush_seg;
			fetch_ip <= {i_flush_off[15:1], 1'b0};
			skip_lo  <= i_flush_off[0];
		end else if (fetch_done) begin
			fetch_ip <= fetch_ip + 16'h2;
			skip_lo  <= 1'b0;
		end
	end
	assign bytes_two = !skip_lo;

	// fetch cut by a branch still runs to T4, its bytes are dropped
	always_ff @(posedge i_clk) begin
		if (i_rst)
			cyc_stale <= 1'b0;
		else if (i_flush && phase != BFU_IDLE)
			cyc_stale <= 1'b1;
		else if (start_op || start_fetch)
			cyc_stale <= 1'b0;
	end
	assign fetch_done = end_cycle && cyc_fetch && !cyc_stale;

	// bytes reserved for the fetch in flight
	always_ff @(posedge i_clk) begin
		if (i_rst || i_flush)
			inflight <= '0;
		else if (start_fetch)
			inflight <= 4'h2;
		else if (lo_now)
			inflight <= bytes_two ? 4'h1 : 4'h0;
		else if (fifo_push)
			inflight <= inflight - 4'h1;
	end

	// byte steering of fetched word into queue
	logic [7:0] hi_hold;
	logic       hi_pend;
	always_ff @(posedge i_clk) begin
		if (i_rst || i_flush) begin
			hi_hold <= '0;
			hi_pend <= 1'b0;
		end else if (fetch_done) begin
			hi_hold <= i_ad_in[15:8];
			hi_pend <= bytes_two;
		end else if (fifo_push && hi_pend)
			hi_pend <= 1'b0;
	end
	assign lo_now    = fetch_done && !i_flush;
	assign fifo_data = lo_now ? (bytes_two ? i_ad_in[7:0]
		: i_ad_in[15:8]) : hi_hold;
	assign fifo_push = (lo_now || hi_pend) && fifo_ready;

	bfu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_queue (
		.i_clk   (i_clk),
		.i_rst   (i_rst || i_flush),
		.i_data  (fifo_data),
		.i_valid (lo_now || hi_pend),
		.o_ready (fifo_ready),
		.o_data  (o_instr_byte),
		.o_valid (o_instr_valid),
		.i_ready (i_instr_take),
		.o_count (fifo_count)
	);

	// operand read capture
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_op_rdata <= '0;
			op_lo      <= '0;
		end else if (end_cycle && !cyc_fetch) begin
			if (cyc_second)
				o_op_rdata <= {i_ad_in[7:0], op_lo};
			else if (cyc_hi_only) begin
				op_lo      <= i_ad_in[15:8];
				o_op_rdata <= {8'h00, i_ad_in[15:8]};
			end else
				o_op_rdata <= cyc_lo_only ? {8'h00, i_ad_in[7:0]}
					: i_ad_in;
		end
	end

	logic is_write;
	assign is_write = cyc_type == `BFU_ST_MEMWR
		|| cyc_type == `BFU_ST_IOWR;
	assign vec_access = !cyc_fetch && cyc_addr <= `BFU_VEC_LIMIT;

	// pins: address in T1, status T2..T4, data T2..T4
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_ad_out             <= '0;
			o_ad_oe_n            <= 1'b1;
			o_addr_status        <= '0;
			o_high_byte_enable_n <= 1'b1;
			o_cycle_type_status  <= `BFU_ST_PASSIVE;
			o_addr_latch         <= 1'b0;
			o_read_n             <= 1'b1;
			o_write_n            <= 1'b1;
			o_mem_io             <= 1'b0;
		end else begin
			o_addr_latch <= 1'b0;
			case (next_phase_view)
			BFU_ADDRESS: begin
				o_ad_out             <= next_cyc_addr[15:0];
				o_ad_oe_n            <= 1'b0;
				o_addr_status        <= next_cyc_addr[19:16];
				o_high_byte_enable_n <= next_cyc_lo_only;
				o_addr_latch         <= 1'b1;
				o_cycle_type_status  <= i_mode_strap
					? `BFU_ST_PASSIVE : next_cyc_type;
				o_mem_io <= next_cyc_type[2];
			end
			BFU_TURNAROUND: begin
				o_addr_status <= {1'b0, i_int_enable, cyc_seg};
				o_ad_oe_n     <= !is_write;
				o_ad_out      <= cyc_wdata;
				o_read_n      <= is_write || !i_mode_strap;
				o_write_n     <= !is_write || !i_mode_strap;
			end
			BFU_IDLE: begin
				o_ad_oe_n           <= 1'b1;
				o_read_n            <= 1'b1;
				o_write_n           <= 1'b1;
				o_cycle_type_status <= `BFU_ST_PASSIVE;
			end
			default: ;
			endcase
		end
	end
	assign next_phase_view = (phase == BFU_IDLE
		&& (start_op || start_fetch)) ? BFU_ADDRESS
		: (phase == BFU_ADDRESS) ? BFU_TURNAROUND
		: (phase == BFU_DATA_LAST) ? BFU_IDLE : BFU_DATA_FIRST;

	a_queue_bound: assert property (@(posedge i_clk) disable iff (i_rst)
		pending <= 4'(QUEUE_DEPTH)) else $error("queue overfilled");
	a_fetch_even: assert property (@(posedge i_clk) disable iff (i_rst)
		o_addr_latch && o_cycle_type_status == `BFU_ST_FETCH
		|-> o_ad_out[0] == 1'b0) else $error("odd fetch");
	a_latch_one: assert property (@(posedge i_clk) disable iff (i_rst)
		o_addr_latch |=> !o_addr_latch) else $error("long strobe");
	a_cycle_len: assert property (@(posedge i_clk) disable iff (i_rst)
		phase == BFU_ADDRESS |=> phase == BFU_TURNAROUND
		##1 phase == BFU_DATA_FIRST) else $error("short cycle");
	a_wait_hold: assert property (@(posedge i_clk) disable iff (i_rst)
		(phase == BFU_DATA_FIRST || phase == BFU_WAIT) && !i_ready
		|=> phase == BFU_WAIT) else $error("wait lost");
	a_zero_bit: assert property (@(posedge i_clk) disable iff (i_rst)
		phase == BFU_DATA_FIRST |-> o_addr_status[3] == 1'b0)
		else $error("status six set");
	a_reset_start: assert property (@(posedge i_clk)
		$fell(i_rst) |-> fetch_ip == `BFU_RESET_OFF
		&& code_seg == `BFU_RESET_SEG) else $error("bad start");
	a_first_show: assert property (@(posedge i_clk) disable iff (i_rst)
		fifo_push && fifo_count == '0 && !i_flush |=> o_instr_valid)
		else $error("byte hidden");
	c_fetch: cover property (@(posedge i_clk) start_fetch);
	c_wait: cover property (@(posedge i_clk) phase == BFU_WAIT);
	c_odd: cover property (@(posedge i_clk) start_op && op_second);
	c_vector: cover property (@(posedge i_clk) end_cycle && vec_access);
	a_addr_match: assert property (@(posedge i_clk) disable iff (i_rst)
		o_addr_latch |-> {o_addr_status, o_ad_out} == cyc_addr)
		else $error("address not of this cycle");
endmodule : bfu_core

// File: test/bfu_mem_model.sv
`timescale 1ns/100ps
module bfu_mem_model (
	input  wire logic        i_clk,
	input  wire logic        i_latch,
	input  wire logic [15:0] i_ad,
	input  wire logic [3:0]  i_hi,
	input  wire logic        i_read_n,
	input  wire logic [2:0]  i_ct,
	input  wire logic        i_oe_n,
	input  wire logic [3:0]  i_waits,
	output logic             o_ready,
	output logic [15:0]      o_ad
);
	logic [19:0] addr = 20'h00000;
	logic [3:0]  wcnt = 4'h0;
	logic [15:0] pat  = 16'h5A5A;
	logic        rd;
	function automatic logic [7:0] mb(input logic [19:0] a);
		return a[7:0] ^ a[15:8] ^ {4'h0, a[19:16]};
	endfunction : mb
	always @(posedge i_clk) begin
		pat <= ~pat;
		if (i_latch) begin
			addr <= {i_hi, i_ad};
			wcnt <= i_waits + 4'h1;
		end else if (wcnt != 4'h0) begin
			wcnt <= wcnt - 4'h1;
		end
	end
	// not ready until the requested waits have passed
	assign o_ready = (wcnt == 4'h0);
	assign rd = !i_read_n || (i_ct inside {3'h1, 3'h4, 3'h5});
	// both banks on bits 19..1; released bus toggles every cycle
	assign o_ad = (rd && i_oe_n)
		? {mb({addr[19:1], 1'b1}), mb({addr[19:1], 1'b0})} : pat;
endmodule : bfu_mem_model

// File: test/bfu_core_tb_top.sv
`timescale 1ns/100ps
module bfu_core_tb_top;
	typedef struct packed {
		logic [19:0] a;
		logic        bhe_n;
		logic [2:0]  ct;
		logic [3:0]  st;
		logic [15:0] wd;
		logic        rd_n;
		logic        wr_n;
		logic        oe_n;
	} bfu_cyc_t;
	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic        i_mode_strap = 1'b0;
	logic        i_int_enable = 1'b0;
	logic        i_flush = 1'b0;
	logic [15:0] i_flush_seg = 16'h0000;
	logic [15:0] i_flush_off = 16'h0000;
	logic        i_op_req = 1'b0;
	logic [2:0]  i_op_type = 3'h0;
	logic [1:0]  i_op_seg_sel = 2'h0;
	logic [15:0] i_op_seg = 16'h0000;
	logic [15:0] i_op_off = 16'h0000;
	logic        i_op_word = 1'b1;
	logic [15:0] i_op_wdata = 16'h0000;
	logic        i_instr_take = 1'b0;
	logic [3:0]  mem_waits = 4'h0;
	logic        i_ready, o_op_busy, o_op_done, o_instr_valid, o_ad_oe_n;
	logic [15:0] i_ad_in, o_ad_out, o_op_rdata, mem_ad;
	logic [7:0]  o_instr_byte;
	logic [3:0]  o_addr_status;
	logic [2:0]  o_cycle_type_status;
	logic        o_high_byte_enable_n, o_addr_latch, o_read_n, o_write_n;
	logic        o_mem_io, prev_lat = 1'b0;
	bfu_cyc_t    cq[$];
	bfu_cyc_t    cur;
	int          ph = 0, cyc = 0, t_lat = 0, t_done = 0;
	int          num_errors = 0, n_checks = 0;

	always #4 i_clk = ~i_clk;
	always @(posedge i_clk) cyc <= cyc + 1;
	assign i_ad_in = o_ad_oe_n ? mem_ad : o_ad_out;

	bfu_core uut (.i_clk, .i_rst, .i_mode_strap, .i_ready, .i_int_enable,
		.i_flush, .i_flush_seg, .i_flush_off, .i_op_req, .i_op_type,
		.i_op_seg_sel, .i_op_seg, .i_op_off, .i_op_word, .i_op_wdata,
		.o_op_busy, .o_op_done, .o_op_rdata, .o_instr_byte, .o_instr_valid,
		.i_instr_take, .i_ad_in, .o_ad_out, .o_ad_oe_n, .o_addr_status,
		.o_high_byte_enable_n, .o_cycle_type_status, .o_addr_latch,
		.o_read_n, .o_write_n, .o_mem_io);
	bfu_mem_model mem (.i_clk, .i_latch(o_addr_latch), .i_ad(o_ad_out),
		.i_hi(o_addr_status), .i_read_n(o_read_n),
		.i_ct(o_cycle_type_status), .i_oe_n(o_ad_oe_n), .i_waits(mem_waits),
		.o_ready(i_ready), .o_ad(mem_ad));

	function automatic logic [7:0] mb(input logic [19:0] a);
		return a[7:0] ^ a[15:8] ^ {4'h0, a[19:16]};
	endfunction : mb

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// bus cycle capture: address in T1, status in T2, data in T3
	always @(negedge i_clk) begin
		prev_lat <= o_addr_latch;
		if (o_addr_latch) begin
			chk(prev_lat, 1'b0);
			cur.a = {o_addr_status, o_ad_out};
			cur.bhe_n = o_high_byte_enable_n;
			t_lat = cyc;
			ph = 1;
		end else if (ph == 1) begin
			cur.ct = o_cycle_type_status;
			cur.st = o_addr_status;
			ph = 2;
		end else if (ph == 2) begin
			cur.wd = o_ad_out;
			cur.rd_n = o_read_n;
			cur.wr_n = o_write_n;
			cur.oe_n = o_ad_oe_n;
			cq.push_back(cur);
			ph = 0;
		end
	end

	task automatic wait_n(input int n);
		int k;
		k = 0;
		while (cq.size() < n) begin
			@(negedge i_clk);
			k++;
			if (k > 300) begin
				chk(32'h0, 32'h1);
				report_and_stop();
			end
		end
	endtask : wait_n

	task automatic take_byte(input logic [19:0] a);
		@(negedge i_clk);
		chk({o_instr_valid, o_instr_byte}, {1'b1, mb(a)});
		i_instr_take = 1'b1;
		@(negedge i_clk);
		i_instr_take = 1'b0;
	endtask : take_byte

	task automatic do_op(input logic [2:0] t, input logic [1:0] s,
			input logic [15:0] off, input logic [15:0] wd, input logic w);
		int k;
		k = 0;
		@(negedge i_clk);
		while (o_op_busy !== 1'b0 && k < 300) begin
			@(negedge i_clk);
			k++;
		end
		cq.delete();
		i_op_req = 1'b1;
		i_op_type = t;
		i_op_seg_sel = s;
		i_op_off = off;
		i_op_wdata = wd;
		i_op_word = w;
		@(negedge i_clk);
		i_op_req = 1'b0;
		while (o_op_done !== 1'b1 && k < 600) begin
			@(negedge i_clk);
			k++;
		end
		t_done = cyc;
		if (k >= 600) begin
			chk(32'h0, 32'h1);
			report_and_stop();
		end
	endtask : do_op

	task automatic s_start();
		wait_n(1);
		chk(cq[0].a, 20'hFFFF0);
		chk(cq[0].bhe_n, 1'b0);
		chk(cq[0].ct, 3'h4);
		chk(cq[0].st, 4'h2);
		wait_n(3);
		repeat (40) @(negedge i_clk);
		chk(cq.size(), 3);
		take_byte(20'hFFFF0);
		repeat (20) @(negedge i_clk);
		chk(cq.size(), 3);
		take_byte(20'hFFFF1);
		wait_n(4);
		chk(cq[3].a, 20'hFFFF6);
		for (int i = 2; i < 6; i++) take_byte(20'hFFFF0 + 20'(i));
	endtask : s_start

	task automatic s_flush();
		repeat (40) @(negedge i_clk);
		cq.delete();
		i_flush = 1'b1;
		i_flush_seg = 16'h1234;
		i_flush_off = 16'h0003;
		@(negedge i_clk);
		i_flush = 1'b0;
		wait_n(1);
		chk({cq[0].a, cq[0].bhe_n}, {20'h12342, 1'b0});
		repeat (10) @(negedge i_clk);
		take_byte(20'h12343);
		repeat (60) @(negedge i_clk);
	endtask : s_flush

	task automatic s_ops();
		logic [2:0]  tt [4] = '{3'h5, 3'h6, 3'h1, 3'h2};
		logic [19:0] a;
		for (int i = 0; i < 4; i++) begin
			a = 20'h00100 + 20'(i * 2);
			i_int_enable = i[0];
			do_op(tt[i], 2'(i), a[15:0], 16'hC3A5 + 16'(i), 1'b1);
			chk(cq.size(), 1);
			chk({cq[0].a, cq[0].bhe_n}, {a, 1'b0});
			chk(cq[0].ct, tt[i]);
			chk(cq[0].st, {1'b0, i[0], 2'(i)});
			if (tt[i][0]) chk(o_op_rdata, {mb(a + 20'h1), mb(a)});
			else chk(cq[0].wd, 16'hC3A5 + 16'(i));
			chk(cq[0].oe_n, tt[i][0]);
			chk(o_mem_io, tt[i][2]);
		end
		i_int_enable = 1'b0;
	endtask : s_ops

	task automatic s_odd();
		do_op(3'h5, 2'h3, 16'h0301, 16'h0000, 1'b1);
		chk(cq.size(), 2);
		chk({cq[0].a, cq[0].bhe_n}, {20'h00301, 1'b0});
		chk({cq[1].a, cq[1].bhe_n}, {20'h00302, 1'b1});
		chk(o_op_rdata, {mb(20'h00302), mb(20'h00301)});
		do_op(3'h6, 2'h3, 16'h0301, 16'hA55A, 1'b1);
		chk({cq[0].wd[15:8], cq[1].wd[7:0]}, 16'h5AA5);
	endtask : s_odd

	task automatic s_wait();
		int len0;
		do_op(3'h5, 2'h3, 16'h0200, 16'h0000, 1'b1);
		len0 = t_done - t_lat;
		chk(32'(len0 >= 4), 1'b1);
		mem_waits = 4'h3;
		do_op(3'h5, 2'h3, 16'h0200, 16'h0000, 1'b1);
		chk(t_done - t_lat - len0, 3);
		chk(o_op_rdata, {mb(20'h00201), mb(20'h00200)});
		mem_waits = 4'h0;
	endtask : s_wait

	task automatic s_min();
		i_mode_strap = 1'b1;
		i_op_seg = 16'h0020;
		do_op(3'h5, 2'h3, 16'h0200, 16'h0000, 1'b1);
		chk({cq[0].ct, cq[0].rd_n}, {3'h7, 1'b0});
		chk(cq[0].a, 20'h00400);
		do_op(3'h6, 2'h3, 16'h0200, 16'h1234, 1'b1);
		chk({cq[0].ct, cq[0].wr_n}, {3'h7, 1'b0});
		i_mode_strap = 1'b0;
		i_op_seg = 16'h0000;
	endtask : s_min

	initial begin
		repeat (3) @(negedge i_clk);
		i_rst = 1'b0;
		s_start();
		s_flush();
		s_ops();
		s_odd();
		s_wait();
		s_min();
		report_and_stop();
	end
endmodule : bfu_core_tb_top
